// ---- rtl/fsps_defs.svh ----
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH
`define FSPS_BIT_EN 0
`define FSPS_BIT_ERASE 1
`define FSPS_BIT_WRITE 2
`define FSPS_BIT_LOCK 3
`define FSPS_BIT_REEN 4
`define FSPS_BIT_BUSY 6
`define FSPS_CMD_LOAD 5'h01
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_REEN 5'h11
`define FSPS_STORE_WIN 4
`define FSPS_LOAD_WIN 3
`define FSPS_Z_LOCK 16'h0001
`define FSPS_Z_FLOW 16'h0000
`define FSPS_Z_FEXT 16'h0002
`define FSPS_Z_FHIGH 16'h0003
`define FSPS_LOCK_RST 6'h3f
`define FSPS_PROG_MIN_NS 3700000
`define FSPS_PROG_MAX_NS 4500000
`define FSPS_CLK_NS 100
`endif

// ---- rtl/fsps_pkg.sv ----
package fsps_pkg;
   typedef enum logic [1:0] {fsps_idle, fsps_erase, fsps_write, fsps_lock}
      fsps_op_e;
   typedef logic [15:0] fsps_word_t;
endpackage : fsps_pkg

// ---- rtl/fsps_timer.sv ----
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_timer #(
   parameter int CYCLES = (`FSPS_PROG_MIN_NS + `FSPS_CLK_NS - 1) /
      `FSPS_CLK_NS
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy,
   output logic done
);
   initial
   begin
      if (CYCLES < 1) $error("Timer count must be at least one");
   end
   logic [31:0] count;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 32'h0000_0000;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            busy <= 1'b1;
            count <= 32'(CYCLES - 1);
         end
         else if (busy)
         begin
            if (count == 32'h0000_0000)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            else
               count <= count - 32'h0000_0001;
         end
      end
   end
endmodule : fsps_timer

// ---- rtl/fsps_sequencer.sv ----
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_sequencer #(
   parameter int PAGE_WORDS = 64,
   parameter int PAGES = 256,
   parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 224,
   parameter int PROG_CYCLES = (`FSPS_PROG_MIN_NS + `FSPS_CLK_NS - 1) /
      `FSPS_CLK_NS,
   parameter logic [7:0] FUSE_LOW = 8'hff,
   parameter logic [7:0] FUSE_HIGH = 8'hff,
   parameter logic [3:0] FUSE_EXT = 4'hf
)(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   output logic [7:0] self_prog_ctrl_status,
   input wire logic store_op,
   input wire logic load_op,
   input wire fsps_pkg::fsps_word_t z_ptr,
   input wire fsps_pkg::fsps_word_t r1r0,
   output logic [7:0] load_data,
   output logic load_special,
   input wire logic eeprom_program_enable,
   input wire logic spm_int_enable,
   output logic spm_irq,
   output logic cpu_halt,
   output logic rww_read_block,
   output logic flash_wr,
   output logic flash_erase,
   output logic [$clog2(PAGES)-1:0] flash_page,
   output logic [$clog2(PAGE_WORDS)-1:0] buf_rd_idx,
   output fsps_pkg::fsps_word_t buf_rd_data,
   output logic [5:0] lock_bits
);
   import fsps_pkg::*;
   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PB = $clog2(PAGES);
   localparam int MAXC = `FSPS_PROG_MAX_NS / `FSPS_CLK_NS;
   initial
   begin
      if (PAGE_WORDS < 2 || (1 << WB) != PAGE_WORDS)
         $error("Page size must be a power of two");
      if (WB + PB + 1 > 16) $error("Flash too large for Z pointer");
      if (PROG_CYCLES < 1 || PROG_CYCLES > MAXC)
         $error("Programming time out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic rst_meta, rst_n;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and command windows
   logic [4:0] cmd;
   logic [2:0] win;
   logic busy_flag;
   fsps_op_e op;
   logic prog_busy, prog_done, prog_start;
   logic [PB-1:0] op_page;
   wire logic armed = cmd[`FSPS_BIT_EN] && win != 3'h0;
   // An EEPROM write starting inside an open window still blocks the op
   wire logic do_store = store_op && armed && !prog_busy &&
      !eeprom_program_enable;
   wire logic do_load = load_op && armed && cmd == `FSPS_CMD_LOCK &&
      win > 3'(`FSPS_STORE_WIN - `FSPS_LOAD_WIN) && !eeprom_program_enable;
   wire logic is_erase = do_store && cmd == `FSPS_CMD_ERASE;
   wire logic is_write = do_store && cmd == `FSPS_CMD_WRITE;
   wire logic is_fill = do_store && cmd == `FSPS_CMD_LOAD;
   wire logic is_lock = do_store && cmd == `FSPS_CMD_LOCK;
   wire logic is_reen = do_store && cmd == `FSPS_CMD_REEN;
   wire logic [PB-1:0] z_page = z_ptr[WB+PB:WB+1];
   wire logic [WB-1:0] z_word = z_ptr[WB:1];

   // Writes are refused while EEPROM programs or flash is busy
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd <= 5'h00;
         win <= 3'h0;
      end
      else if (ctrl_wr && !eeprom_program_enable && !prog_busy)
      begin
         cmd <= ctrl_wdata[4:0];
         win <= 3'(`FSPS_STORE_WIN);
      end
      else if (do_store || do_load || win == 3'h1)
      begin
         // Erase, write and lock keep enable set until the flash is done
         cmd <= (is_erase || is_write || is_lock) ? cmd : 5'h00;
         win <= 3'h0;
      end
      else if (win != 3'h0)
         win <= win - 3'h1;
      else if (prog_done)
         cmd <= 5'h00;
   end

   always_comb
   begin
      self_prog_ctrl_status = 8'h00;
      self_prog_ctrl_status[4:0] = cmd;
      self_prog_ctrl_status[`FSPS_BIT_BUSY] = busy_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flash operation timing
   fsps_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(prog_start),
      .busy(prog_busy),
      .done(prog_done)
   );
   assign prog_start = is_erase || is_write || is_lock;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op <= fsps_idle;
         op_page <= '0;
      end
      else if (prog_start)
      begin
         op_page <= z_page;
         case (1'b1)
            is_erase: op <= fsps_erase;
            is_write: op <= fsps_write;
            default: op <= fsps_lock;
         endcase
      end
      else if (prog_done)
         op <= fsps_idle;
   end

   wire logic in_no_read_while_write_section = op_page >= PB'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
   assign cpu_halt = prog_busy && in_no_read_while_write_section &&
      (op == fsps_erase || op == fsps_write);
   assign flash_page = op_page;
   assign flash_erase = prog_done && op == fsps_erase;
   assign flash_wr = prog_done && op == fsps_write;

   // Any erase or write blocks READ_WHILE_WRITE_SECTION; only re-enable releases it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         busy_flag <= 1'b0;
      else if (is_erase || is_write)
         busy_flag <= 1'b1;
      else if (is_reen)
         busy_flag <= 1'b0;
   end
   assign rww_read_block = busy_flag;

   ////////////////////////////////////////////////////////////////////////
   // Temporary page buffer
   fsps_word_t page_buf [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] buf_valid;
   wire logic buf_clear = (flash_wr) || is_reen ||
      (eeprom_program_enable && buf_valid != '0);
   genvar gi;
   generate
      for (gi = 0; gi < PAGE_WORDS; gi++)
      begin : g_buf
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               buf_valid[gi] <= 1'b0;
            else if (buf_clear)
               buf_valid[gi] <= 1'b0;
            else if (is_fill && z_word == WB'(gi))
               buf_valid[gi] <= 1'b1;
         end
         always_ff @(posedge ref_clk)
         begin
            if (is_fill && z_word == WB'(gi))
               page_buf[gi] <= r1r0;
         end
      end
   endgenerate
   logic [WB-1:0] rd_idx;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_idx <= '0;
      else
         rd_idx <= z_word;
   end
   assign buf_rd_idx = rd_idx;
   // Erased words read back as all ones
   assign buf_rd_data = buf_valid[rd_idx] ? page_buf[rd_idx] : 16'hffff;

   ////////////////////////////////////////////////////////////////////////
   // Lock bits and readback
   logic [5:0] lock_req;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_bits <= `FSPS_LOCK_RST;
      else if (prog_done && op == fsps_lock)
         lock_bits <= lock_bits & lock_req;
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_req <= 6'h3f;
      else if (is_lock)
         lock_req <= r1r0[5:0];
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_data <= 8'h00;
         load_special <= 1'b0;
      end
      else
      begin
         load_special <= do_load;
         if (do_load)
         begin
            if (z_ptr == `FSPS_Z_LOCK)
               load_data <= {2'b11, lock_bits};
            else if (z_ptr == `FSPS_Z_FLOW)
               load_data <= FUSE_LOW;
            else if (z_ptr == `FSPS_Z_FHIGH)
               load_data <= FUSE_HIGH;
            else if (z_ptr == `FSPS_Z_FEXT)
               load_data <= {4'hf, FUSE_EXT};
            else
               load_data <= 8'hff;
         end
      end
   end

   assign spm_irq = spm_int_enable && !cmd[`FSPS_BIT_EN];

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_win;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(win == 3'(`FSPS_STORE_WIN)) ##0 !store_op [*4] |=>
         !cmd[`FSPS_BIT_EN] || prog_busy;
   endproperty
   a_win: assert property (p_win) else $error("enable not cleared");
   property p_irq;
      @(posedge ref_clk) disable iff (!rst_n)
      spm_int_enable && !cmd[`FSPS_BIT_EN] |-> spm_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_busy;
      @(posedge ref_clk) disable iff (!rst_n)
      prog_busy && op != fsps_lock |-> rww_read_block;
   endproperty
   a_busy: assert property (p_busy) else $error("busy lost");
   property p_halt;
      @(posedge ref_clk) disable iff (!rst_n)
      op == fsps_lock |-> !cpu_halt &&
         (!$rose(prog_busy) || $stable(rww_read_block));
   endproperty
   a_halt: assert property (p_halt) else $error("lock halts cpu");
   property p_ee;
      @(posedge ref_clk) disable iff (!rst_n)
      eeprom_program_enable |=> !load_special && !$rose(prog_busy);
   endproperty
   a_ee: assert property (p_ee) else $error("eeprom block");
   property p_clr;
      @(posedge ref_clk) disable iff (!rst_n)
      is_reen |=> buf_valid == '0;
   endproperty
   a_clr: assert property (p_clr) else $error("buffer kept");
   property p_fill;
      @(posedge ref_clk) disable iff (!rst_n)
      is_fill && !buf_clear |=> buf_valid[$past(z_word)];
   endproperty
   a_fill: assert property (p_fill) else $error("fill lost");
   property p_bad;
      @(posedge ref_clk) disable iff (!rst_n)
      store_op && !armed |-> !prog_start ##1
         (!$rose(prog_busy) && $stable(lock_req));
   endproperty
   a_bad: assert property (p_bad) else $error("late store acted");
   c_erase: cover property (@(posedge ref_clk) flash_erase);
   c_write: cover property (@(posedge ref_clk) flash_wr);
   c_read: cover property (@(posedge ref_clk) load_special);
endmodule : fsps_sequencer

// ---- sim/fsps_cpu_model.sv ----
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_cpu_model (
   input wire logic ref_clk,
   input wire logic eeprom_program_enable,
   output logic ctrl_wr,
   output logic [7:0] ctrl_wdata,
   output logic store_op,
   output logic load_op,
   output fsps_pkg::fsps_word_t z_ptr,
   output fsps_pkg::fsps_word_t r1r0
);
   import fsps_pkg::*;
   initial
   begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 8'h00;
      store_op = 1'b0;
      load_op = 1'b0;
      z_ptr = 16'h0000;
      r1r0 = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   // Every task starts and ends just after a rising edge
   task automatic spm(input logic [4:0] cmd, input fsps_word_t z, d,
      input int late, input logic ee_ok);
      int n;
      logic lk;
      n = 0;
      lk = (cmd == `FSPS_CMD_LOCK);
      while (ee_ok && eeprom_program_enable && n < 100)
      begin
         step();
         n++;
      end
      ctrl_wr = 1'b1;
      ctrl_wdata = {3'h0, cmd};
      z_ptr = lk ? `FSPS_Z_LOCK : z;
      r1r0 = lk ? (d | 16'h00c0) : d;
      step();
      ctrl_wr = 1'b0;
      repeat (late) step();
      store_op = 1'b1;
      step();
      store_op = 1'b0;
   endtask : spm
   task automatic lpm(input logic [4:0] cmd, input fsps_word_t z);
      ctrl_wr = (cmd != 5'h00);
      ctrl_wdata = {3'h0, cmd};
      z_ptr = z;
      step();
      ctrl_wr = 1'b0;
      load_op = 1'b1;
      step();
      load_op = 1'b0;
   endtask : lpm
   task automatic point(input fsps_word_t z);
      z_ptr = z;
      step();
   endtask : point
endmodule : fsps_cpu_model

// ---- sim/fsps_sequencer_tb_top.sv ----
`timescale 1ns/10ps
`include "fsps_defs.svh"
module fsps_sequencer_tb_top;
   import fsps_pkg::*;
   localparam int PC = 10;
   typedef struct {logic [4:0] cmd; fsps_word_t z; logic sp;
      logic [7:0] e; logic [7:0] m;} fsps_row_s;
   logic ref_clk = 1'b0;
   logic nrst, ctrl_wr, store_op, load_op, load_special;
   logic eeprom_program_enable, spm_int_enable, spm_irq, cpu_halt;
   logic rww_read_block, flash_wr, flash_erase;
   logic [7:0] ctrl_wdata, self_prog_ctrl_status, load_data, flash_page;
   logic [7:0] page;
   logic [5:0] buf_rd_idx, lock_bits;
   logic [1:0] kind;
   fsps_word_t z_ptr, r1r0, buf_rd_data;
   int errors = 0;
   int check_count = 0;
   int pulses = 0;
   fsps_row_s rows [5] = '{
      '{`FSPS_CMD_LOCK, `FSPS_Z_LOCK, 1'b1, 8'h3f, 8'h3f},
      '{`FSPS_CMD_LOCK, `FSPS_Z_FLOW, 1'b1, 8'h5a, 8'hff},
      '{`FSPS_CMD_LOCK, `FSPS_Z_FHIGH, 1'b1, 8'ha5, 8'hff},
      '{`FSPS_CMD_LOCK, `FSPS_Z_FEXT, 1'b1, 8'h09, 8'h0f},
      '{5'h00, `FSPS_Z_FLOW, 1'b0, 8'h00, 8'h00}};
   always #50 ref_clk = ~ref_clk;
   // Short program time keeps the run small
   fsps_sequencer #(.PROG_CYCLES(PC), .FUSE_LOW(8'h5a),
      .FUSE_HIGH(8'ha5), .FUSE_EXT(4'h9)) fsps_sequencer_i (
      .ref_clk(ref_clk), .nrst(nrst), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata),
      .self_prog_ctrl_status(self_prog_ctrl_status),
      .store_op(store_op), .load_op(load_op), .z_ptr(z_ptr), .r1r0(r1r0),
      .load_data(load_data), .load_special(load_special),
      .eeprom_program_enable(eeprom_program_enable),
      .spm_int_enable(spm_int_enable), .spm_irq(spm_irq),
      .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
      .flash_wr(flash_wr), .flash_erase(flash_erase),
      .flash_page(flash_page), .buf_rd_idx(buf_rd_idx),
      .buf_rd_data(buf_rd_data), .lock_bits(lock_bits));
   fsps_cpu_model fsps_cpu_model_i (.ref_clk(ref_clk),
      .eeprom_program_enable(eeprom_program_enable), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .store_op(store_op), .load_op(load_op),
      .z_ptr(z_ptr), .r1r0(r1r0));
   // Sampled on the falling edge, away from the launching edge
   always @(negedge ref_clk)
   if (flash_wr || flash_erase)
   begin
      pulses++;
      kind = {flash_wr, flash_erase};
      page = flash_page;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   task automatic chk(input string nm, input logic [15:0] e, g);
      check_count++;
      if (e !== g)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic rd(input logic [4:0] cmd, input fsps_word_t z,
      input logic sp, input logic [7:0] e, m);
      fsps_cpu_model_i.lpm(cmd, z);
      chk("load_special", {15'h0, sp}, {15'h0, load_special});
      step();
      if (sp)
         chk("load_data", {8'h0, e & m}, {8'h0, load_data & m});
      chk("enable_bit", 16'h0, {15'h0, self_prog_ctrl_status[0]});
   endtask : rd
   task automatic peek(input logic [5:0] i, input fsps_word_t e);
      fsps_cpu_model_i.point({9'h0, i, 1'b0});
      chk("buf_idx", {10'h0, i}, {10'h0, buf_rd_idx});
      chk("buf_data", e, buf_rd_data);
   endtask : peek
   task automatic prog(input logic [4:0] cmd, input fsps_word_t z, d,
      input int late, input logic halt, busy, input logic [1:0] k,
      input logic [7:0] pg, input logic long);
      int n;
      int p0;
      n = 0;
      p0 = pulses;
      fsps_cpu_model_i.spm(cmd, z, d, late, 1'b1);
      step();
      chk("cpu_halt", {15'h0, halt}, {15'h0, cpu_halt});
      chk("busy_flag", {15'h0, busy}, {15'h0, self_prog_ctrl_status[6]});
      chk("rww_block", {15'h0, busy}, {15'h0, rww_read_block});
      if (long)
         chk("irq_busy", 16'h0, {15'h0, spm_irq});
      while (self_prog_ctrl_status[0] !== 1'b0 && n < 60)
      begin
         step();
         n++;
      end
      chk("op_length", {15'h0, long}, {15'h0, n >= PC - 2 && n <= PC + 3});
      chk("pulse_count", {15'h0, k != 2'b00}, 16'(pulses - p0));
      if (k != 2'b00)
      begin
         chk("pulse_kind", {14'h0, k}, {14'h0, kind});
         chk("flash_page", {8'h0, pg}, {8'h0, page});
      end
      chk("irq_done", 16'h1, {15'h0, spm_irq});
   endtask : prog
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(100 * 6000);
      errors++;
      give_verdict();
   end
   initial
   begin
      nrst = 1'b0;
      eeprom_program_enable = 1'b0;
      spm_int_enable = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (5) step();
      chk("status_rst", 16'h0, {8'h0, self_prog_ctrl_status});
      chk("lock_rst", 16'h3f, {10'h0, lock_bits});
      chk("irq_off", 16'h0, {15'h0, spm_irq});
      spm_int_enable = 1'b1;
      step();
      chk("irq_on", 16'h1, {15'h0, spm_irq});
      foreach (rows[i])
         rd(rows[i].cmd, rows[i].z, rows[i].sp, rows[i].e, rows[i].m);
      fsps_cpu_model_i.spm(`FSPS_CMD_LOAD, 16'h000a, 16'h1234, 0, 1'b1);
      peek(6'd5, 16'h1234);
      peek(6'd6, 16'hffff);
      // EEPROM busy: command refused and the loaded word is lost
      eeprom_program_enable = 1'b1;
      step();
      fsps_cpu_model_i.spm(`FSPS_CMD_LOCK, 16'h0, 16'h0, 0, 1'b0);
      chk("lock_ee", 16'h3f, {10'h0, lock_bits});
      chk("enable_ee", 16'h0, {15'h0, self_prog_ctrl_status[0]});
      eeprom_program_enable = 1'b0;
      peek(6'd5, 16'hffff);
      prog(`FSPS_CMD_ERASE, 16'h01ff, 16'h5555, 0, 0, 1, 2'b01, 8'd3, 1);
      fsps_cpu_model_i.spm(`FSPS_CMD_LOAD, 16'h000a, 16'h1234, 0, 1'b1);
      prog(`FSPS_CMD_REEN, 16'h0, 16'h0, 0, 0, 0, 2'b00, 8'd0, 0);
      peek(6'd5, 16'hffff);
      prog(`FSPS_CMD_ERASE, 16'h7300, 16'h0, 0, 1, 1, 2'b01, 8'd230, 1);
      prog(`FSPS_CMD_REEN, 16'h0, 16'h0, 0, 0, 0, 2'b00, 8'd0, 0);
      fsps_cpu_model_i.spm(`FSPS_CMD_LOAD, 16'h0012, 16'habcd, 0, 1'b1);
      peek(6'd9, 16'habcd);
      prog(`FSPS_CMD_WRITE, 16'h7300, 16'h9999, 0, 1, 1, 2'b10, 8'd230, 1);
      peek(6'd9, 16'hffff);
      prog(`FSPS_CMD_REEN, 16'h0, 16'h0, 0, 0, 0, 2'b00, 8'd0, 0);
      prog(`FSPS_CMD_LOCK, 16'h7777, 16'h00f6, 0, 0, 0, 2'b00, 8'd0, 1);
      chk("lock_prog", 16'h36, {10'h0, lock_bits});
      rd(`FSPS_CMD_LOCK, `FSPS_Z_LOCK, 1'b1, 8'h36, 8'h3f);
      prog(`FSPS_CMD_ERASE, 16'h0200, 16'h0, 5, 0, 0, 2'b00, 8'd0, 0);
      prog(5'h07, 16'h0200, 16'h0, 0, 0, 0, 2'b00, 8'd0, 0);
      chk("lock_keep", 16'h36, {10'h0, lock_bits});
      // EEPROM starts inside an open window: the read is refused
      fork
         fsps_cpu_model_i.lpm(`FSPS_CMD_LOCK, `FSPS_Z_LOCK);
         begin
            step();
            eeprom_program_enable = 1'b1;
         end
      join
      chk("load_ee", 16'h0, {15'h0, load_special});
      eeprom_program_enable = 1'b0;
      repeat (4) step();
      chk("enable_ee2", 16'h0, {15'h0, self_prog_ctrl_status[0]});
      // Reset in mid-run drops a loaded word
      fsps_cpu_model_i.spm(`FSPS_CMD_LOAD, 16'h000a, 16'h5678, 0,
         1'b1);
      nrst = 1'b0;
      step();
      nrst = 1'b1;
      repeat (3) step();
      chk("status_rst2", 16'h0, {8'h0, self_prog_ctrl_status});
      peek(6'd5, 16'hffff);
      give_verdict();
   end
endmodule : fsps_sequencer_tb_top
